// ===== bench/i2c_register_slave_port_tb_top.sv
// Bench for the register slave port against a behavioural memory model.
// Assumes SDA has a pull-up; stimulus at falling edges.
`timescale 1ns/1ps
module i2c_register_slave_port_tb_top;
  logic       ref_clk = 1'b0;
  logic       resetn  = 1'b0;
  logic [2:0] sel     = 3'h3;
  logic       sda_out, sda_oe_n, wr_stb, busy, scl, sda_m, ack;
  logic [7:0] wr_addr, wr_data, reg_ptr, got, a, d, ga, gd, lf = 8'h3e;
  logic [7:0] mem [256];
  int         fails = 0, checks = 0;
  wire        sda_w = sda_m & (sda_oe_n | sda_out);
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (wr_stb === 1'b1) begin
    ga <= wr_addr;
    gd <= wr_data;
  end
  irs_slave i_dut (.ref_clk(ref_clk), .resetn(resetn), .scl_in(scl), .sda_in(sda_w), .addr_sel(sel),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data),
    .reg_ptr(reg_ptr), .busy(busy));
  irs_mst i_mst (.ref_clk(ref_clk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic tx(input logic [7:0] v, input logic m);
    for (int i = 7; i >= 0; i--) i_mst.bx(v[i], got[i]);
    i_mst.bx(m, ack);
  endtask
  task automatic report_and_stop;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Whole run is far below this bound
  initial begin
    repeat (90000) @(posedge ref_clk);
    fails++;
    report_and_stop;
  end
  initial begin
    repeat (4) @(negedge ref_clk);
    resetn = 1'b1;
    for (int k = 0; k < 6; k++) begin
      lf = nx(lf);
      a = lf;
      lf = nx(lf);
      d = lf;
      i_mst.st;
      tx({4'ha, sel, 1'b0}, 1'b1);
      cmp("dev ack", 8'h00, {7'h00, ack});
      cmp("busy", 8'h01, {7'h00, busy});
      tx(a, 1'b1);
      cmp("ptr ack", 8'h00, {7'h00, ack});
      tx(d, 1'b1);
      cmp("wr ack", 8'h00, {7'h00, ack});
      mem[a] = d;
      for (int r = 0; r < 2; r++) begin
        i_mst.st;
        tx({4'ha, sel, 1'b1}, 1'b1);
        cmp("rd ack", 8'h00, {7'h00, ack});
        tx(8'hff, 1'b0);
        cmp("rd data", mem[a], got);
      end
      i_mst.sp;
      cmp("wr addr", a, ga);
      cmp("wr data", d, gd);
      cmp("pointer", a, reg_ptr);
      i_mst.st;
      tx({4'ha, ~sel, 1'b0}, 1'b1);
      cmp("foreign ack", 8'h01, {7'h00, ack});
      i_mst.sp;
      cmp("idle", 8'h00, {7'h00, busy});
      sel = lf[2:0];
    end
    report_and_stop;
  end
endmodule

// ===== bench/irs_mst.sv
// Bus master model: drives the serial clock and its half of the data line.
// Assumes the bench resolves open-drain SDA into sda_w.
`timescale 1ns/1ps
module irs_mst (
  input  wire logic ref_clk,
  input  wire logic sda_w,
  output logic      scl,
  output logic      sda_m
);
  // ==========================================================
  // Line phases
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end
  task automatic p(input logic c, input logic d, input int n);
    scl   = c;
    sda_m = d;
    repeat (n) @(negedge ref_clk);
  endtask
  // ==========================================================
  // Conditions and bits
  task automatic st;
    p(1'b0, 1'b1, 6);
    p(1'b1, 1'b1, 6);
    p(1'b1, 1'b0, 6);
    p(1'b0, 1'b0, 6);
  endtask
  task automatic sp;
    p(1'b0, 1'b0, 6);
    p(1'b1, 1'b0, 6);
    p(1'b1, 1'b1, 6);
  endtask
  // One bit is 25 cycles, a 125 ns link clock
  task automatic bx(input logic b, output logic r);
    p(1'b0, b, 6);
    p(1'b1, b, 13);
    r = sda_w;
    p(1'b0, b, 6);
  endtask
endmodule

// ===== design/irs_pkg.sv
// Constants and types for the two-wire register slave port.
// Assumes a 200 MHz ref_clk that oversamples a standard or fast serial bus.
package irs_pkg;

  // ==========================================================
  // Addressing
  localparam logic [3:0] DEV_ADDR_HI = 4'ha;
  localparam int         SEL_W       = 3;
  localparam int         BYTE_W      = 8;
  localparam logic [3:0] BIT_LAST    = 4'h8;
  localparam logic [3:0] BIT_ZERO    = 4'h0;
  localparam logic [3:0] BIT_ONE     = 4'h1;
  localparam int         MSB         = 7;

  // ==========================================================
  // Reset values
  localparam logic [7:0] PTR_RST     = 8'h00;
  localparam logic [7:0] BYTE_RST    = 8'h00;
  localparam logic [1:0] LINE_IDLE   = 2'h3;
  localparam logic [2:0] SEL_RST     = 3'h0;

  // ==========================================================
  // Bus rates; both are far below the sampling rate
  localparam int CLK_HZ       = 200000000;
  localparam int STD_HZ       = 100000;
  localparam int FAST_HZ      = 400000;
  localparam int FAST_CYCLES  = CLK_HZ / FAST_HZ;
  localparam int STD_CYCLES   = CLK_HZ / STD_HZ;

  // ==========================================================
  // Protocol states
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_DEVADR = 4'h1,
    ST_ACKDEV = 4'h2,
    ST_PTR    = 4'h3,
    ST_ACKPTR = 4'h4,
    ST_WDATA  = 4'h5,
    ST_ACKWR  = 4'h6,
    ST_RDATA  = 4'h7,
    ST_MACK   = 4'h8
  } irs_state_t;

endpackage

// ===== design/irs_slave.sv
// Two-wire register slave port: address match, pointer, one-byte write and read.
// Assumes an external master drives the clock line; the bench resolves open-drain SDA.
// Operation
// RULE_01: The port is only ever a slave and never drives the serial clock line.
// RULE_02: The port answers to a 7-bit address of 1010 followed by the three select pins.
// RULE_03: The port works at both the 100 kHz and the 400 kHz bus rates.
// RULE_04: SDA changes only while SCL is low, except for start, repeated start and stop.
// RULE_05: The master toggles SCL only while SDA is stable unless it signals start or stop.
// RULE_06: An access opens with start, the address MSB first and a zero direction bit, then an acknowledge.
// RULE_07: The next byte, MSB first, is latched as the register pointer and acknowledged.
// RULE_08: In a write, one data byte MSB first is stored at the pointer and acknowledged.
// RULE_09: After a write the master may stop or use a repeated start for a new access.
// RULE_10: The pointer holds its value until reset or a new address-setting sequence.
// RULE_11: A read resends the address with a one direction bit after a repeated start, and is acknowledged.
// RULE_12: After that acknowledge the port shifts out the eight bits of the pointed register.
// RULE_13: The master acknowledges the read byte and then stops or issues a repeated start.
// RULE_14: The port drives SDA only for its acknowledges and read data bits.
// RULE_15: The master forms a repeated start by raising SDA, then SCL, then dropping SDA.
// RULE_16: An access with a non-matching address gets no acknowledge and SDA stays released.
`timescale 1ns/1ps
module irs_slave (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic [2:0] addr_sel,
  output logic            sda_out,
  output logic            sda_oe_n,
  output logic            wr_stb,
  output logic [7:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic [7:0]      reg_ptr,
  output logic            busy
);

  // ==========================================================
  // Pin synchronisers
  logic [1:0]                     line_s;
  logic [irs_pkg::SEL_W-1:0]      sel_s;

  // Bus at 400 kHz gives hundreds of samples per bit, so no glitch filter
  irs_sync #(.W(2), .INIT(irs_pkg::LINE_IDLE)) u_line_sync ( // RULE_03
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .d       ({scl_in, sda_in}),
    .q       (line_s)
  );

  irs_sync #(.W(irs_pkg::SEL_W), .INIT(irs_pkg::SEL_RST)) u_sel_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .d       (addr_sel),
    .q       (sel_s)
  );

  // ==========================================================
  // Edge and condition detection
  logic        scl_d;
  logic        sda_d;
  wire logic   scl_s      = line_s[1];
  wire logic   sda_s      = line_s[0];
  wire logic   scl_rise   = scl_s & ~scl_d;
  wire logic   scl_fall   = ~scl_s & scl_d;
  // SDA moving while SCL is high can only be a start or a stop
  wire logic   start_det  = scl_s & scl_d & sda_d & ~sda_s; // RULE_04
  wire logic   stop_det   = scl_s & scl_d & ~sda_d & sda_s; // RULE_04
  wire logic   quiet      = ~start_det & ~stop_det;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // ==========================================================
  // Register store
  logic [7:0]  mem [0:255];
  wire  [7:0]  rd_byte = mem[reg_ptr];

  // ==========================================================
  // Protocol state
  irs_pkg::irs_state_t state;
  irs_pkg::irs_state_t next_state;
  logic [3:0]          bit_cnt;
  logic [3:0]          next_bit_cnt;
  logic [7:0]          shreg;
  logic [7:0]          next_shreg;
  logic                rd_dir;
  logic                next_rd_dir;
  logic                next_sda_out;
  logic                next_sda_oe_n;
  logic                next_wr_stb;
  logic [7:0]          next_reg_ptr;
  logic                next_busy;

  // ==========================================================
  // Decode of the current phase
  wire logic       rx_phase   = (state == irs_pkg::ST_DEVADR) |
                                (state == irs_pkg::ST_PTR) |
                                (state == irs_pkg::ST_WDATA);
  wire logic       ack_phase  = (state == irs_pkg::ST_ACKDEV) |
                                (state == irs_pkg::ST_ACKPTR) |
                                (state == irs_pkg::ST_ACKWR);
  wire logic       tx_phase   = ack_phase | (state == irs_pkg::ST_RDATA); // RULE_14
  wire logic       byte_done  = scl_fall & (bit_cnt == irs_pkg::BIT_LAST);
  wire logic [6:0] own_addr   = {irs_pkg::DEV_ADDR_HI, sel_s}; // RULE_02
  wire logic       addr_hit   = (shreg[irs_pkg::MSB:1] == own_addr); // RULE_02 RULE_16
  wire logic       dir_bit    = shreg[0];
  wire logic [7:0] shift_in   = {shreg[irs_pkg::MSB-1:0], sda_s};
  wire logic [7:0] shift_out  = {shreg[irs_pkg::MSB-1:0], 1'b0};
  wire logic [3:0] cnt_inc    = bit_cnt + irs_pkg::BIT_ONE;
  // Bits are taken on the rising edge, when the master holds SDA still
  wire logic       count_bit  = quiet & scl_rise & (rx_phase | (state == irs_pkg::ST_RDATA)); // RULE_04

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_state    = state;
    next_bit_cnt  = bit_cnt;
    next_shreg    = shreg;
    next_rd_dir   = rd_dir;
    next_sda_out  = sda_out;
    next_sda_oe_n = sda_oe_n;
    next_wr_stb   = 1'b0;
    next_reg_ptr  = reg_ptr;
    if (start_det) begin
      // A repeated start abandons whatever byte was in flight
      next_state    = irs_pkg::ST_DEVADR; // RULE_06 RULE_11
      next_bit_cnt  = irs_pkg::BIT_ZERO;
      next_sda_oe_n = 1'b1;
      next_sda_out  = 1'b1;
    end else if (stop_det) begin
      next_state    = irs_pkg::ST_IDLE;
      next_sda_oe_n = 1'b1;
      next_sda_out  = 1'b1;
    end else begin
      if (count_bit) begin
        next_bit_cnt = cnt_inc;
      end
      if (count_bit & rx_phase) begin
        next_shreg = shift_in; // RULE_06 RULE_07 RULE_08
      end
      case (state)
        irs_pkg::ST_IDLE: begin
          next_sda_oe_n = 1'b1; // RULE_16
          next_sda_out  = 1'b1;
        end
        irs_pkg::ST_DEVADR: begin
          if (byte_done & addr_hit) begin
            next_state    = irs_pkg::ST_ACKDEV; // RULE_02 RULE_06 RULE_11
            next_rd_dir   = dir_bit;
            next_sda_oe_n = 1'b0;
            next_sda_out  = 1'b0;
          end else if (byte_done) begin
            // Foreign address: stay off the line until the next start
            next_state = irs_pkg::ST_IDLE; // RULE_16
          end
        end
        irs_pkg::ST_ACKDEV: begin
          if (scl_fall & rd_dir) begin
            next_state    = irs_pkg::ST_RDATA; // RULE_12
            next_bit_cnt  = irs_pkg::BIT_ZERO;
            next_shreg    = rd_byte;
            next_sda_oe_n = 1'b0;
            next_sda_out  = rd_byte[irs_pkg::MSB];
          end else if (scl_fall) begin
            next_state    = irs_pkg::ST_PTR;
            next_bit_cnt  = irs_pkg::BIT_ZERO;
            next_sda_oe_n = 1'b1;
            next_sda_out  = 1'b1;
          end
        end
        irs_pkg::ST_PTR: begin
          if (byte_done) begin
            next_state    = irs_pkg::ST_ACKPTR;
            next_reg_ptr  = shreg; // RULE_07 RULE_10
            next_sda_oe_n = 1'b0;
            next_sda_out  = 1'b0;
          end
        end
        irs_pkg::ST_ACKPTR: begin
          if (scl_fall) begin
            next_state    = irs_pkg::ST_WDATA;
            next_bit_cnt  = irs_pkg::BIT_ZERO;
            next_sda_oe_n = 1'b1;
            next_sda_out  = 1'b1;
          end
        end
        irs_pkg::ST_WDATA: begin
          if (byte_done) begin
            next_state    = irs_pkg::ST_ACKWR;
            next_wr_stb   = 1'b1; // RULE_08
            next_sda_oe_n = 1'b0;
            next_sda_out  = 1'b0;
          end
        end
        irs_pkg::ST_ACKWR: begin
          // One data byte per write; the master restarts for more
          if (scl_fall) begin
            next_state    = irs_pkg::ST_IDLE;
            next_sda_oe_n = 1'b1;
            next_sda_out  = 1'b1;
          end
        end
        irs_pkg::ST_RDATA: begin
          if (byte_done) begin
            // Ninth slot belongs to the master for its acknowledge
            next_state    = irs_pkg::ST_MACK; // RULE_14
            next_sda_oe_n = 1'b1;
            next_sda_out  = 1'b1;
          end else if (scl_fall) begin
            next_shreg   = shift_out; // RULE_12
            next_sda_out = shreg[irs_pkg::MSB-1];
          end
        end
        irs_pkg::ST_MACK: begin
          if (scl_fall) begin
            next_state = irs_pkg::ST_IDLE;
          end
        end
        default: begin
          next_state    = irs_pkg::ST_IDLE;
          next_sda_oe_n = 1'b1;
          next_sda_out  = 1'b1;
        end
      endcase
    end
  end

  assign next_busy = (next_state != irs_pkg::ST_IDLE);

  // ==========================================================
  // State registers
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state   <= irs_pkg::ST_IDLE;
      bit_cnt <= irs_pkg::BIT_ZERO;
      shreg   <= irs_pkg::BYTE_RST;
      rd_dir  <= 1'b0;
      busy    <= 1'b0;
    end else begin
      state   <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg   <= next_shreg;
      rd_dir  <= next_rd_dir;
      busy    <= next_busy;
    end
  end

  // ==========================================================
  // Line drive; the port has no SCL output at all
  always_ff @(posedge ref_clk) begin // RULE_01 RULE_14
    if (!resetn) begin
      sda_out  <= 1'b1;
      sda_oe_n <= 1'b1;
    end else begin
      sda_out  <= next_sda_out;
      sda_oe_n <= next_sda_oe_n;
    end
  end

  // ==========================================================
  // Pointer and write port
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      reg_ptr <= irs_pkg::PTR_RST; // RULE_10
      wr_stb  <= 1'b0;
      wr_addr <= irs_pkg::PTR_RST;
      wr_data <= irs_pkg::BYTE_RST;
    end else begin
      reg_ptr <= next_reg_ptr;
      wr_stb  <= next_wr_stb;
      if (next_wr_stb) begin
        wr_addr <= reg_ptr;
        wr_data <= shreg;
      end
    end
  end

  // Store has no reset; unwritten locations read as unknown
  always_ff @(posedge ref_clk) begin
    if (wr_stb) begin
      mem[wr_addr] <= wr_data; // RULE_08
    end
  end

  // ==========================================================
  // Checks
  sequence s_wr_byte;
    (state == irs_pkg::ST_WDATA) && byte_done;
  endsequence

  sequence s_wr_pulse;
    (wr_stb && (wr_data == $past(shreg))) ##1 !wr_stb;
  endsequence

  sequence s_rd_turn;
    (state == irs_pkg::ST_ACKDEV) && scl_fall && rd_dir;
  endsequence

  chk_wr_pulse: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_08
    s_wr_byte |=> s_wr_pulse)
    else $error("write strobe or data wrong after data byte");
  chk_read_first: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_11 RULE_12
    s_rd_turn |=> ((state == irs_pkg::ST_RDATA) && !sda_oe_n && (sda_out == $past(rd_byte[irs_pkg::MSB]))))
    else $error("first read bit not driven after read acknowledge");
  chk_ack_drive: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_14
    ack_phase |-> (!sda_oe_n && !sda_out))
    else $error("acknowledge slot not driven low");
  chk_drive_scope: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_14 RULE_16
    !sda_oe_n |-> tx_phase)
    else $error("SDA driven outside acknowledge or read data");
  chk_foreign_off: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_16
    ((state == irs_pkg::ST_DEVADR) && byte_done && !addr_hit) |=> (sda_oe_n && (state == irs_pkg::ST_IDLE)))
    else $error("foreign address not ignored");
  chk_ptr_latch: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_07
    ((state == irs_pkg::ST_PTR) && byte_done) |=> (reg_ptr == $past(shreg)))
    else $error("pointer not latched from register address byte");
  chk_ptr_hold: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_10
    !((state == irs_pkg::ST_PTR) && byte_done) |=> $stable(reg_ptr))
    else $error("pointer changed outside address setting");
  chk_start_seen: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_04 RULE_06
    start_det |=> ((state == irs_pkg::ST_DEVADR) && sda_oe_n))
    else $error("start condition not taken");

endmodule

// ===== design/irs_sync.sv
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes each bit is an independent level; no bus coherence.
`timescale 1ns/1ps
module irs_sync #(
  parameter int              W    = 1,
  parameter logic [W-1:0]    INIT = '0
) (
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ==========================================================
  // Meta stage read only by the second stage
  logic [W-1:0] meta;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      meta <= INIT;
      q    <= INIT;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule
